// >>> ahl_axis_model.sv
// Purpose: Behavioural axis behind the homing core: encoder, index pulse, hard stops, motor current.
// Assumes: One count every four clocks while motion runs.
// Notes: Index every 64 counts; hard stops at plus and minus STOP.
`timescale 1ns/10ps
module ahl_axis_model #(
   parameter int STOP = 300
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic motionRun,
   input wire logic motionDir,
   output logic signed [31:0] encPos,
   output logic encIndex,
   output logic [15:0] motorCurrent
);
   logic [1:0] preCount;
   logic push;
   // A blocked rotor draws high current, so homing against a stop sees the real signature.
   assign push = motionRun && (motionDir ? encPos >= STOP : encPos <= -STOP);
   assign motorCurrent = push ? 16'h8000 : 16'h0010;
   assign encIndex = encPos[5:0] == 6'h00;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         encPos <= '0;
         preCount <= '0;
      end else if (motionRun && !push) begin
         preCount <= preCount + 2'h1;
         if (preCount == 2'h3) begin
            encPos <= motionDir ? encPos + 1 : encPos - 1;
         end
      end
   end
endmodule

// >>> ahl_homing_core.sv
// Purpose: Homing sequencer, reference arithmetic and software end-limit guard.
// Assumes: Encoder position, index pulse, switches and current are synchronous to clk_sys.
// Notes: Motion is requested via motionDir and motionRun; the drive does the profiling.
`timescale 1ns/10ps
module ahl_homing_core #(
   parameter int COUNTS_PER_REV = 4096,
   parameter int DC_BASE_SPACING = 1000
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic signed [31:0] encPos,
   input wire logic encIndex,
   input wire logic homeSwitch,
   input wire logic revSwitchNeg,
   input wire logic revSwitchPos,
   input wire logic distMark,
   input wire logic [15:0] motorCurrent,
   output logic motionRun,
   output logic motionDir,
   output logic followErrEnable,
   output logic rampStop,
   output logic deenergize,
   output logic signed [31:0] moveTarget,
   output logic moveGo
);
   initial begin
      if (COUNTS_PER_REV < 2 || COUNTS_PER_REV > 65536) $error("COUNTS_PER_REV out of range");
      if (DC_BASE_SPACING < 1) $error("DC_BASE_SPACING must be positive");
   end

   // ----------------------------------------
   // Homing state machine
   // ----------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_SEEK = 5'b00010,
      ST_INDEX = 5'b00100,
      ST_MARK2 = 5'b01000,
      ST_DONE = 5'b10000
   } ahl_state_t;

   ahl_state_t state_reg, state_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [15:0] curThresh_reg, curThresh_next;
   logic signed [31:0] zeroOffset_reg, zeroOffset_next;
   logic signed [31:0] limitPos_reg, limitPos_next;
   logic signed [31:0] limitNeg_reg, limitNeg_next;
   logic signed [15:0] adjustDeg_reg, adjustDeg_next;
   logic signed [31:0] target_reg, target_next;
   logic signed [31:0] machineZero_reg, machineZero_next;
   logic signed [31:0] refPoint_reg, refPoint_next;
   logic signed [31:0] sensorDist_reg, sensorDist_next;
   logic signed [31:0] edgePos_reg, edgePos_next;
   logic signed [31:0] markPos_reg, markPos_next;
   logic [15:0] errCode_reg, errCode_next;
   logic homed_reg, homed_next;
   logic fault_reg, fault_next;
   logic refused_reg, refused_next;
   logic dir_reg, dir_next;
   logic moveGo_reg, moveGo_next;
   logic signed [31:0] moveTarget_reg, moveTarget_next;
   logic homeSw_reg, index_reg, mark_reg;
   logic [31:0] readData_reg, readData_next;
   logic ack_reg, ack_next;

   logic [7:0] mode;
   ahl_pkg::ahl_opmode_t opMode;
   ahl_pkg::ahl_react_t react;
   logic revByCurrent;
   logic startCmd, moveCmd, ackCmd;
   logic overCurrent, isCurrentMode, isDcMode, isRevMode;
   logic indexRise, homeEdge, markRise, swEdgeShifted;
   logic signed [31:0] adjCounts;
   logic signed [47:0] adjProd;
   logic wrCtrl;

   ahl_limit_if lim ();
   ahl_limit_check u_check (
      .lim(lim)
   );

   assign mode = ctrl_reg[ahl_pkg::CTRL_MODE_LSB +: 8];
   assign opMode = ahl_pkg::ahl_opmode_t'(ctrl_reg[ahl_pkg::CTRL_OPMODE_LSB +: 2]);
   assign react = ahl_pkg::ahl_react_t'(ctrl_reg[ahl_pkg::CTRL_REACT_LSB +: 2]);
   assign revByCurrent = ctrl_reg[ahl_pkg::CTRL_REVCUR_BIT];
   assign wrCtrl = avs_write && !ack_reg && avs_address == ahl_pkg::ADDR_CTRL;
   assign startCmd = wrCtrl && avs_writedata[ahl_pkg::CTRL_START_BIT];
   assign moveCmd = avs_write && !ack_reg && avs_address == ahl_pkg::ADDR_TARGET;
   assign ackCmd = wrCtrl && avs_writedata[ahl_pkg::CTRL_ACK_BIT];
   assign overCurrent = motorCurrent > curThresh_reg;
   assign isCurrentMode = mode == ahl_pkg::MODE_STOP_POS || mode == ahl_pkg::MODE_STOP_NEG;
   assign isDcMode = mode >= ahl_pkg::MODE_DC_LO && mode <= ahl_pkg::MODE_DC_HI;
   assign isRevMode = mode >= ahl_pkg::MODE_REV_NEG_LO && mode <= ahl_pkg::MODE_REV_NEG_HI;
   assign indexRise = encIndex && !index_reg;
   assign homeEdge = homeSwitch != homeSw_reg;
   assign markRise = distMark && !mark_reg;

   // Degrees become counts; the shifted switch point is the raw edge plus this offset.
   assign adjProd = 48'(adjustDeg_reg) * 48'(COUNTS_PER_REV) / 48'sd360;
   assign adjCounts = adjProd[31:0];
   assign swEdgeShifted = encPos == edgePos_reg + adjCounts;

   assign lim.target = target_next;
   assign lim.curPos = encPos;
   assign lim.refPoint = refPoint_reg;
   assign lim.limitPos = limitPos_reg;
   assign lim.limitNeg = limitNeg_reg;
   assign lim.opMode = 2'(opMode);
   assign lim.armed = homed_reg && state_reg == ST_IDLE;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      curThresh_next = curThresh_reg;
      zeroOffset_next = zeroOffset_reg;
      limitPos_next = limitPos_reg;
      limitNeg_next = limitNeg_reg;
      adjustDeg_next = adjustDeg_reg;
      target_next = target_reg;
      machineZero_next = machineZero_reg;
      refPoint_next = refPoint_reg;
      sensorDist_next = sensorDist_reg;
      edgePos_next = edgePos_reg;
      markPos_next = markPos_reg;
      errCode_next = errCode_reg;
      homed_next = homed_reg;
      fault_next = fault_reg;
      refused_next = refused_reg;
      dir_next = dir_reg;
      moveGo_next = 1'b0;
      moveTarget_next = moveTarget_reg;
      readData_next = readData_reg;
      ack_next = (avs_read || avs_write) && !ack_reg;

      if (avs_write && !ack_reg) begin
         if (avs_address == ahl_pkg::ADDR_CTRL) begin
            ctrl_next = {16'h0000, avs_writedata[15:0]};
         end else if (avs_address == ahl_pkg::ADDR_CUR_THRESH) begin
            curThresh_next = avs_writedata[15:0];
         end else if (avs_address == ahl_pkg::ADDR_ZERO_OFFSET) begin
            zeroOffset_next = avs_writedata;
         end else if (avs_address == ahl_pkg::ADDR_LIMIT_POS) begin
            limitPos_next = avs_writedata;
         end else if (avs_address == ahl_pkg::ADDR_LIMIT_NEG) begin
            limitNeg_next = avs_writedata;
         end else if (avs_address == ahl_pkg::ADDR_ADJUST_DEG) begin
            // Out-of-range angles are clamped rather than rejected.
            if ($signed(avs_writedata) > 32'(ahl_pkg::ADJUST_MAX)) begin
               adjustDeg_next = ahl_pkg::ADJUST_MAX;
            end else if ($signed(avs_writedata) < 32'(ahl_pkg::ADJUST_MIN)) begin
               adjustDeg_next = ahl_pkg::ADJUST_MIN;
            end else begin
               adjustDeg_next = avs_writedata[15:0];
            end
         end else if (avs_address == ahl_pkg::ADDR_TARGET) begin
            target_next = avs_writedata;
         end
      end

      if (avs_read && !ack_reg) begin
         if (avs_address == ahl_pkg::ADDR_CTRL) begin
            readData_next = ctrl_reg;
         end else if (avs_address == ahl_pkg::ADDR_STATUS) begin
            readData_next = {28'h0000000, refused_reg, fault_reg, state_reg != ST_IDLE, homed_reg};
         end else if (avs_address == ahl_pkg::ADDR_CUR_THRESH) begin
            readData_next = {16'h0000, curThresh_reg};
         end else if (avs_address == ahl_pkg::ADDR_ZERO_OFFSET) begin
            readData_next = zeroOffset_reg;
         end else if (avs_address == ahl_pkg::ADDR_LIMIT_POS) begin
            readData_next = limitPos_reg;
         end else if (avs_address == ahl_pkg::ADDR_LIMIT_NEG) begin
            readData_next = limitNeg_reg;
         end else if (avs_address == ahl_pkg::ADDR_ADJUST_DEG) begin
            readData_next = 32'(adjustDeg_reg);
         end else if (avs_address == ahl_pkg::ADDR_TARGET) begin
            readData_next = target_reg;
         end else if (avs_address == ahl_pkg::ADDR_REF_POINT) begin
            readData_next = refPoint_reg;
         end else if (avs_address == ahl_pkg::ADDR_SENSOR_DIST) begin
            readData_next = sensorDist_reg;
         end else if (avs_address == ahl_pkg::ADDR_MACHINE_ZERO) begin
            readData_next = machineZero_reg;
         end else if (avs_address == ahl_pkg::ADDR_ERROR_CODE) begin
            readData_next = {16'h0000, errCode_reg};
         end else begin
            readData_next = 32'h0000_0000;
         end
      end

      // A move is judged against the limits in the cycle it is written.
      if (moveCmd && state_reg == ST_IDLE) begin
         if (lim.overPos || lim.overNeg) begin
            refused_next = 1'b1;
            errCode_next = lim.overPos ? ahl_pkg::ERR_LIMIT_POS : ahl_pkg::ERR_LIMIT_NEG;
            if (react != ahl_pkg::REACT_NONE) begin
               fault_next = 1'b1;
            end
         end else begin
            moveTarget_next = avs_writedata;
            moveGo_next = 1'b1;
         end
      end else if (ackCmd) begin
         fault_next = 1'b0;
         refused_next = 1'b0;
         errCode_next = 16'h0000;
      end

      case (state_reg)
         ST_IDLE: begin
            if (startCmd) begin
               homed_next = 1'b0;
               if (avs_writedata[7:0] == ahl_pkg::MODE_HERE) begin
                  machineZero_next = encPos;
                  state_next = ST_DONE;
               end else begin
                  // Modes 11..14 start toward the negative reversal switch.
                  dir_next = avs_writedata[7:0] == ahl_pkg::MODE_STOP_POS ||
                     avs_writedata[7:0] == ahl_pkg::MODE_ZP_POS;
                  state_next = ST_SEEK;
               end
            end
         end
         ST_SEEK: begin
            if (isCurrentMode) begin
               if (overCurrent) begin
                  machineZero_next = encPos;
                  state_next = ST_DONE;
               end
            end else if (mode == ahl_pkg::MODE_ZP_NEG || mode == ahl_pkg::MODE_ZP_POS) begin
               if (indexRise) begin
                  machineZero_next = encPos;
                  state_next = ST_DONE;
               end
            end else if (isDcMode) begin
               if (markRise) begin
                  markPos_next = encPos;
                  state_next = ST_MARK2;
               end
            end else if (homeEdge) begin
               edgePos_next = encPos;
               state_next = ST_INDEX;
            end
            if (!isCurrentMode && ((revByCurrent && overCurrent) || (!dir_reg && revSwitchNeg) ||
                  (dir_reg && revSwitchPos))) begin
               dir_next = !dir_reg;
            end
         end
         ST_INDEX: begin
            if (indexRise && encPos != edgePos_reg + adjCounts) begin
               machineZero_next = encPos;
               sensorDist_next = encPos - edgePos_reg;
               state_next = ST_DONE;
            end else if (swEdgeShifted) begin
               edgePos_next = encPos;
            end
         end
         ST_MARK2: begin
            if (markRise) begin
               // Absolute zero follows from how far the mark gap departs from the base spacing.
               machineZero_next = encPos - (encPos - markPos_reg - 32'(DC_BASE_SPACING));
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            refPoint_next = machineZero_reg + zeroOffset_reg;
            homed_next = 1'b1;
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         ctrl_reg <= ahl_pkg::CTRL_RESET;
         curThresh_reg <= 16'hffff;
         zeroOffset_reg <= 32'h0000_0000;
         limitPos_reg <= 32'h0000_0000;
         limitNeg_reg <= 32'h0000_0000;
         adjustDeg_reg <= ahl_pkg::ADJUST_RESET;
         target_reg <= 32'h0000_0000;
         machineZero_reg <= 32'h0000_0000;
         refPoint_reg <= 32'h0000_0000;
         sensorDist_reg <= 32'h0000_0000;
         edgePos_reg <= 32'h0000_0000;
         markPos_reg <= 32'h0000_0000;
         errCode_reg <= 16'h0000;
         homed_reg <= 1'b0;
         fault_reg <= 1'b0;
         refused_reg <= 1'b0;
         dir_reg <= 1'b0;
         moveGo_reg <= 1'b0;
         moveTarget_reg <= 32'h0000_0000;
         homeSw_reg <= 1'b0;
         index_reg <= 1'b0;
         mark_reg <= 1'b0;
         readData_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         curThresh_reg <= curThresh_next;
         zeroOffset_reg <= zeroOffset_next;
         limitPos_reg <= limitPos_next;
         limitNeg_reg <= limitNeg_next;
         adjustDeg_reg <= adjustDeg_next;
         target_reg <= target_next;
         machineZero_reg <= machineZero_next;
         refPoint_reg <= refPoint_next;
         sensorDist_reg <= sensorDist_next;
         edgePos_reg <= edgePos_next;
         markPos_reg <= markPos_next;
         errCode_reg <= errCode_next;
         homed_reg <= homed_next;
         fault_reg <= fault_next;
         refused_reg <= refused_next;
         dir_reg <= dir_next;
         moveGo_reg <= moveGo_next;
         moveTarget_reg <= moveTarget_next;
         homeSw_reg <= homeSwitch;
         index_reg <= encIndex;
         mark_reg <= distMark;
         readData_reg <= readData_next;
         ack_reg <= ack_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign avs_readdata = readData_reg;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign motionRun = state_reg == ST_SEEK || state_reg == ST_INDEX || state_reg == ST_MARK2;
   assign motionDir = dir_reg;
   assign followErrEnable = !(isCurrentMode && state_reg != ST_IDLE);
   assign rampStop = fault_reg && react != ahl_pkg::REACT_NONE;
   assign deenergize = fault_reg && react == ahl_pkg::REACT_DEENERGIZE;
   assign moveTarget = moveTarget_reg;
   assign moveGo = moveGo_reg;
endmodule

// >>> ahl_homing_core_checker.sv
// Purpose: Port-level assertions for the homing core.
// Assumes: One wait state per register access.
// Notes: Bound to every homing core instance.
`timescale 1ns/10ps
module ahl_homing_core_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic motionRun,
   input wire logic followErrEnable,
   input wire logic rampStop,
   input wire logic deenergize,
   input wire logic signed [31:0] moveTarget,
   input wire logic moveGo
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("access not answered after one wait state");
   chk_read_stand: assert property ($changed(avs_readdata) |-> $past(avs_read))
      else $error("read data changed without a read");
   chk_fe_idle: assert property (!motionRun [*2] |-> followErrEnable)
      else $error("following error reaction off while idle");
   chk_deen_stop: assert property (deenergize |-> rampStop)
      else $error("de-energize without ramp stop");
   chk_run_nogo: assert property (motionRun |-> !moveGo)
      else $error("move accepted during homing");
   // Writes are taken at the first edge of an access, while waitrequest is still high.
   chk_go_write: assert property (moveGo |->
      $past(avs_write && avs_waitrequest && avs_address == ahl_pkg::ADDR_TARGET))
      else $error("move without target write");
   chk_go_data: assert property (moveGo |-> moveTarget == $past(avs_writedata))
      else $error("move target differs from written value");
   chk_go_pulse: assert property (moveGo |=> !moveGo)
      else $error("move strobe longer than one cycle");
endmodule
bind ahl_homing_core ahl_homing_core_checker u_ahl_homing_core_checker (.*);

// >>> ahl_homing_core_test.sv
// Purpose: Self-checking bench for homing modes, offsets and software end limits.
// Assumes: Axis model starts at zero; mark input stays idle; home switch is on from count -220 upward.
// Notes: Distance-coded modes 130 to 133 are left to later work.
`timescale 1ns/10ps
module ahl_homing_core_test;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [5:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata, got;
   logic avs_waitrequest, encIndex, motionRun, motionDir, followErrEnable, rampStop, deenergize, moveGo;
   logic homeSwitch = 1'b0;
   logic revSwitchNeg = 1'b0;
   logic revSwitchPos = 1'b0;
   logic distMark = 1'b0;
   logic signed [31:0] encPos, moveTarget;
   logic [15:0] motorCurrent;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   int goCount = 0;
   ahl_homing_core u_ahl_homing_core (.*);
   ahl_axis_model u_ahl_axis_model (.clk_sys(clk_sys), .reset(reset), .motionRun(motionRun),
      .motionDir(motionDir), .encPos(encPos), .encIndex(encIndex), .motorCurrent(motorCurrent));
   initial forever #5 clk_sys = ~clk_sys;
   // The home switch covers travel from count -220 upward, so from -256 it is crossed only after a reversal.
   always @(posedge clk_sys) begin
      homeSwitch <= encPos >= -32'sd220;
   end
   always @(posedge clk_sys) begin
      cycles++;
      goCount += moveGo;
      if (cycles == 60000) begin
         fails++;
         summarize();
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Request is held until the rising edge at which waitrequest is sampled low.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      got = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, '0);
      cmp(got, e);
   endtask
   task automatic t_regs;
      rchk(ahl_pkg::ADDR_CTRL, ahl_pkg::CTRL_RESET);
      rchk(ahl_pkg::ADDR_STATUS, 32'h0);
      rchk(6'h3c, 32'h0);
      rchk(ahl_pkg::ADDR_ADJUST_DEG, 32'h0);
      bus(1'b1, ahl_pkg::ADDR_ADJUST_DEG, 32'h12c);
      rchk(ahl_pkg::ADDR_ADJUST_DEG, 32'hb4);
      bus(1'b1, ahl_pkg::ADDR_ADJUST_DEG, 32'hfffffed4);
      bus(1'b0, ahl_pkg::ADDR_ADJUST_DEG, '0);
      cmp(got[15:0], 16'hff4c);
   endtask
   task automatic home(input logic [7:0] m, input logic [31:0] z, input logic d);
      bus(1'b1, ahl_pkg::ADDR_CTRL, 32'h0001_0800 | m);
      if (m != ahl_pkg::MODE_HERE) begin
         wait (motionRun === 1'b1);
         @(negedge clk_sys);
         cmp(motionDir, d);
         cmp(followErrEnable, !m[7]);
      end else begin
         cmp(motionRun, 1'b0);
      end
      do bus(1'b0, ahl_pkg::ADDR_STATUS, '0); while (got[1] !== 1'b0);
      cmp(got[0], 1'b1);
      rchk(ahl_pkg::ADDR_MACHINE_ZERO, z);
   endtask
   task automatic mv(input logic [31:0] t, input int ok, input logic [15:0] code);
      int g0;
      g0 = goCount;
      bus(1'b1, ahl_pkg::ADDR_TARGET, t);
      repeat (3) @(posedge clk_sys);
      cmp(goCount - g0, ok);
      if (ok == 1) begin
         cmp(moveTarget, t);
      end else begin
         rchk(ahl_pkg::ADDR_ERROR_CODE, {16'h0, code});
         bus(1'b0, ahl_pkg::ADDR_STATUS, '0);
         cmp(got[3], 1'b1);
      end
   endtask
   task automatic t_limits;
      bus(1'b1, ahl_pkg::ADDR_LIMIT_POS, 32'h64);
      bus(1'b1, ahl_pkg::ADDR_LIMIT_NEG, 32'hffffff9c);
      mv(32'hffffff6d, 1, 16'h0);
      mv(32'hfffffea5, 1, 16'h0);
      mv(32'hfffffea4, 0, ahl_pkg::ERR_LIMIT_NEG);
      bus(1'b1, ahl_pkg::ADDR_CTRL, 32'h0004_0800);
      for (int r = 0; r < 3; r++) begin
         bus(1'b1, ahl_pkg::ADDR_CTRL, r << 10);
         mv(32'hffffff6e, 0, ahl_pkg::ERR_LIMIT_POS);
         cmp(rampStop, r != 0);
         cmp(deenergize, r == 2);
         bus(1'b1, ahl_pkg::ADDR_CTRL, 32'h0004_0000 | (r << 10));
      end
      bus(1'b1, ahl_pkg::ADDR_CTRL, 32'h0000_0900);
      mv(32'h0000_8000, 1, 16'h0);
      bus(1'b1, ahl_pkg::ADDR_CTRL, 32'h0000_0a00);
      mv(32'hffffff64, 1, 16'h0);
      mv(32'hffffff65, 0, ahl_pkg::ERR_LIMIT_POS);
   endtask
   // Mode 11 runs negative into the stop, reverses on current, then finds switch and index.
   task automatic t_switch;
      bus(1'b1, ahl_pkg::ADDR_ZERO_OFFSET, 32'hfffffff6);
      bus(1'b1, ahl_pkg::ADDR_CTRL, 32'h0001_1800 | 32'(ahl_pkg::MODE_REV_NEG_LO));
      wait (motionRun === 1'b1);
      @(negedge clk_sys);
      cmp(motionDir, 1'b0);
      wait (motionDir === 1'b1);
      cmp(encPos, 32'hfffffed4);
      do bus(1'b0, ahl_pkg::ADDR_STATUS, '0); while (got[1] !== 1'b0);
      rchk(ahl_pkg::ADDR_MACHINE_ZERO, 32'hffffff40);
      rchk(ahl_pkg::ADDR_SENSOR_DIST, 32'h0000_001c);
      rchk(ahl_pkg::ADDR_REF_POINT, 32'hffffff36);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      t_regs();
      bus(1'b1, ahl_pkg::ADDR_CUR_THRESH, 32'h4000);
      home(ahl_pkg::MODE_STOP_POS, 32'h12c, 1'b1);
      home(ahl_pkg::MODE_ZP_NEG, 32'h100, 1'b0);
      home(ahl_pkg::MODE_STOP_NEG, 32'hfffffed4, 1'b0);
      home(ahl_pkg::MODE_ZP_POS, 32'hffffff00, 1'b1);
      bus(1'b1, ahl_pkg::ADDR_ZERO_OFFSET, 32'h5);
      home(ahl_pkg::MODE_HERE, 32'hffffff00, 1'b0);
      rchk(ahl_pkg::ADDR_REF_POINT, 32'hffffff05);
      bus(1'b1, ahl_pkg::ADDR_ZERO_OFFSET, 32'h9);
      rchk(ahl_pkg::ADDR_REF_POINT, 32'hffffff05);
      home(ahl_pkg::MODE_HERE, 32'hffffff00, 1'b0);
      rchk(ahl_pkg::ADDR_REF_POINT, 32'hffffff09);
      t_limits();
      t_switch();
      summarize();
   end
endmodule

// >>> ahl_limit_check.sv
// Purpose: Decides whether a move target breaks the software end limits.
// Assumes: Limits are offsets from the reference chosen by operating mode.
// Notes: Purely combinational.
`timescale 1ns/10ps
module ahl_limit_check (
   ahl_limit_if.check lim
);
   logic signed [32:0] base;
   logic signed [32:0] hiBound;
   logic signed [32:0] loBound;
   logic signed [32:0] tgt;

   always_comb begin
      // Absolute mode is anchored to the homing reference, continuous to where the axis is now.
      base = (lim.opMode == 2'(ahl_pkg::OPM_CONTINUOUS)) ? 33'(lim.curPos) : 33'(lim.refPoint);
      hiBound = base + 33'(lim.limitPos);
      loBound = base + 33'(lim.limitNeg);
      tgt = 33'(lim.target);
      lim.overPos = 1'b0;
      lim.overNeg = 1'b0;
      if (lim.armed && lim.opMode != 2'(ahl_pkg::OPM_RESET)) begin
         lim.overPos = tgt > hiBound;
         lim.overNeg = tgt < loBound;
      end
   end
endmodule

// >>> ahl_limit_if.sv
// Purpose: Carries a move request between the homing core and the limit checker.
// Assumes: Positions are 32-bit signed counts.
// Notes: Checker answers combinationally.
`timescale 1ns/10ps
interface ahl_limit_if;
   logic signed [31:0] target;
   logic signed [31:0] curPos;
   logic signed [31:0] refPoint;
   logic signed [31:0] limitPos;
   logic signed [31:0] limitNeg;
   logic [1:0] opMode;
   logic armed;
   logic overPos;
   logic overNeg;
   modport core (output target, curPos, refPoint, limitPos, limitNeg, opMode, armed, input overPos, overNeg);
   modport check (input target, curPos, refPoint, limitPos, limitNeg, opMode, armed, output overPos, overNeg);
endinterface

// >>> ahl_pkg.sv
// Purpose: Shared constants and types for the axis homing and travel-limit block.
// Assumes: 32-bit Avalon-MM register port, word-aligned byte addresses.
// Notes: Positions are signed encoder counts.
package ahl_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [5:0] ADDR_CTRL = 6'h00;
   localparam logic [5:0] ADDR_STATUS = 6'h04;
   localparam logic [5:0] ADDR_CUR_THRESH = 6'h08;
   localparam logic [5:0] ADDR_ZERO_OFFSET = 6'h0c;
   localparam logic [5:0] ADDR_LIMIT_POS = 6'h10;
   localparam logic [5:0] ADDR_LIMIT_NEG = 6'h14;
   localparam logic [5:0] ADDR_ADJUST_DEG = 6'h18;
   localparam logic [5:0] ADDR_TARGET = 6'h1c;
   localparam logic [5:0] ADDR_REF_POINT = 6'h20;
   localparam logic [5:0] ADDR_SENSOR_DIST = 6'h24;
   localparam logic [5:0] ADDR_MACHINE_ZERO = 6'h28;
   localparam logic [5:0] ADDR_ERROR_CODE = 6'h2c;
   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_OPMODE_LSB = 8;
   localparam int CTRL_REACT_LSB = 10;
   localparam int CTRL_REVCUR_BIT = 12;
   localparam int CTRL_START_BIT = 16;
   localparam int CTRL_MOVE_BIT = 17;
   localparam int CTRL_ACK_BIT = 18;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0800;
   // ----------------------------------------
   // Homing mode numbers
   // ----------------------------------------
   localparam logic [7:0] MODE_REV_NEG_LO = 8'h0b;
   localparam logic [7:0] MODE_REV_NEG_HI = 8'h0e;
   localparam logic [7:0] MODE_ZP_NEG = 8'h21;
   localparam logic [7:0] MODE_ZP_POS = 8'h22;
   localparam logic [7:0] MODE_HERE = 8'h23;
   localparam logic [7:0] MODE_STOP_POS = 8'h80;
   localparam logic [7:0] MODE_STOP_NEG = 8'h81;
   localparam logic [7:0] MODE_DC_LO = 8'h82;
   localparam logic [7:0] MODE_DC_REV = 8'h84;
   localparam logic [7:0] MODE_DC_HI = 8'h85;
   // ----------------------------------------
   // Limits, defaults and error codes
   // ----------------------------------------
   localparam logic signed [15:0] ADJUST_MIN = -16'sd180;
   localparam logic signed [15:0] ADJUST_MAX = 16'sd180;
   localparam logic signed [15:0] ADJUST_RESET = 16'sd0;
   localparam logic [15:0] ERR_LIMIT_POS = 16'h7323;
   localparam logic [15:0] ERR_LIMIT_NEG = 16'h7324;
   localparam int STATUS_HOMED_BIT = 0;
   localparam int STATUS_BUSY_BIT = 1;
   localparam int STATUS_FAULT_BIT = 2;
   localparam int STATUS_REFUSED_BIT = 3;

   typedef enum logic [1:0] {
      OPM_ABSOLUTE = 2'h0,
      OPM_RESET = 2'h1,
      OPM_CONTINUOUS = 2'h2
   } ahl_opmode_t;

   typedef enum logic [1:0] {
      REACT_NONE = 2'h0,
      REACT_STOP = 2'h1,
      REACT_DEENERGIZE = 2'h2
   } ahl_react_t;
endpackage
